// ==== common/fcs_pkg.sv ====
// Package for the flash command sequencer host controller.
// Assumes a 250 MHz clock and an APB slave for the controller's own registers.
package fcs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ID_PAUSE_US = 10;
  localparam int LOCK_PAUSE_MS = 10;
  localparam int BYTE_GAP_NS = 200;
  localparam int ID_PAUSE_CYC = ID_PAUSE_US * CLK_MHZ;
  localparam int LOCK_PAUSE_CYC = LOCK_PAUSE_MS * 1000 * CLK_MHZ;
  localparam int BYTE_GAP_CYC = (BYTE_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = 32'h0000_0020;
  localparam logic [17:0] CMD_ADDR_A = 18'h0_5555;
  localparam logic [17:0] CMD_ADDR_B = 18'h0_2AAA;
  localparam logic [7:0] D_AA = 8'hAA;
  localparam logic [7:0] D_55 = 8'h55;
  localparam logic [7:0] D_80 = 8'h80;
  localparam logic [7:0] D_ID6 = 8'h60;
  localparam logic [7:0] D_ID3 = 8'h90;
  localparam logic [7:0] D_EXIT = 8'hF0;
  localparam logic [7:0] D_PROT_ON = 8'hA0;
  localparam logic [7:0] D_PROT_OFF = 8'h20;
  localparam logic [7:0] D_ERASE = 8'h10;
  localparam logic [7:0] D_LOCK = 8'h40;
  localparam logic [17:0] LOCK_FIRST_ADDR = 18'h0_0000;
  localparam logic [17:0] LOCK_LAST_ADDR = 18'h3_FFFF;
  localparam logic [7:0] LOCK_FIRST_DATA = 8'h00;
  localparam logic [7:0] LOCK_LAST_DATA = 8'hFF;
  localparam logic [17:0] ID_MAKER_ADDR = 18'h0_0000;
  localparam logic [17:0] ID_DEV_ADDR = 18'h0_0001;
  localparam logic [17:0] ID_LOCK_FIRST = 18'h0_0002;
  localparam logic [17:0] ID_LOCK_LAST = 18'h3_FFF2;
  // Controller register map, byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Command codes written to REG_CMD
  typedef enum logic [3:0] {
    FCS_OP_NONE, FCS_OP_READ, FCS_OP_PROG, FCS_OP_ID_ENTER6, FCS_OP_ID_ENTER3,
    FCS_OP_ID_EXIT, FCS_OP_PROT_OFF, FCS_OP_ERASE, FCS_OP_LOCK_FIRST,
    FCS_OP_LOCK_LAST, FCS_OP_POLL, FCS_OP_HW_ID
  } fcs_op_t;
endpackage : fcs_pkg

// ==== common/fcs_cyc_if.sv ====
// Carrier between the sequencer and its flash bus cycle engine.
// Assumes one clock; a request stands until done pulses.
`timescale 1ns/1ns
interface fcs_cyc_if;
  logic req;
  logic wr;
  logic hv;
  logic [17:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output hv, output addr, output wdata,
    input done, input rdata);
  modport eng (input req, input wr, input hv, input addr, input wdata,
    output done, output rdata);
endinterface : fcs_cyc_if

// ==== design/fcs_cycle.sv ====
// Flash bus cycle engine: one read or one write strobe per request.
// Assumes the flash data pins are sampled synchronously to clk.
`timescale 1ns/1ns
module fcs_cycle (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  fcs_cyc_if.eng cyc,
  output logic chip_sel_n_q,
  output logic out_en_n_q,
  output logic wr_en_n_q,
  output logic id_high_voltage_line_q,
  output logic [17:0] addr_q,
  output logic [7:0] dq_out_q,
  output logic dq_oe_q,
  input wire logic [7:0] dq_in
);
  import fcs_pkg::*;
  typedef enum logic [1:0] {FCS_C_IDLE, FCS_C_STROBE, FCS_C_GAP, FCS_C_DONE} fcs_cst_t;
  fcs_cst_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] rd_q, rd_d;
  logic cs_d, oe_d, we_d, hv_d, doe_d;
  logic [17:0] a_d;
  logic [7:0] do_d;

  // Strobe length is a fixed count, long enough for the slowest access time
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    cs_d = chip_sel_n_q;
    oe_d = out_en_n_q;
    we_d = wr_en_n_q;
    hv_d = id_high_voltage_line_q;
    a_d = addr_q;
    do_d = dq_out_q;
    doe_d = dq_oe_q;
    case (st_q)
      FCS_C_IDLE: begin
        if (cyc.req) begin
          st_d = FCS_C_STROBE;
          cnt_d = 8'(STROBE_CYC);
          a_d = cyc.addr;
          do_d = cyc.wdata;
          doe_d = cyc.wr;
          cs_d = 1'b0;
          oe_d = cyc.wr;
          we_d = ~cyc.wr;
          hv_d = cyc.hv;
        end
      end
      FCS_C_STROBE: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          rd_d = dq_in;
          cs_d = 1'b1;
          oe_d = 1'b1;
          we_d = 1'b1;
          cnt_d = 8'(BYTE_GAP_CYC);
          st_d = FCS_C_GAP;
        end
      end
      // Strobes rest high between bytes, else write-high and toggle-read recovery are too short
      FCS_C_GAP: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          st_d = FCS_C_DONE;
        end
      end
      FCS_C_DONE: begin
        // Data and high voltage dropped after strobe rise gives hold time
        doe_d = 1'b0;
        hv_d = 1'b0;
        st_d = FCS_C_IDLE;
      end
      default: st_d = FCS_C_IDLE;
    endcase
  end

  // State registers, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= FCS_C_IDLE;
      cnt_q <= 8'h00;
      rd_q <= 8'h00;
      chip_sel_n_q <= 1'b1;
      out_en_n_q <= 1'b1;
      wr_en_n_q <= 1'b1;
      id_high_voltage_line_q <= 1'b0;
      addr_q <= 18'h0_0000;
      dq_out_q <= 8'h00;
      dq_oe_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      chip_sel_n_q <= cs_d;
      out_en_n_q <= oe_d;
      wr_en_n_q <= we_d;
      id_high_voltage_line_q <= hv_d;
      addr_q <= a_d;
      dq_out_q <= do_d;
      dq_oe_q <= doe_d;
    end
  end

  assign cyc.done = (st_q == FCS_C_DONE);
  assign cyc.rdata = rd_q;

  // Never both strobes low together
  a_strobe_excl: assert property (@(posedge clk) disable iff (!reset_n)
    !(!out_en_n_q && !wr_en_n_q)) else $error("read and write strobes overlap");
  a_hv_read_only: assert property (@(posedge clk) disable iff (!reset_n)
    id_high_voltage_line_q && !chip_sel_n_q |-> !out_en_n_q && wr_en_n_q)
    else $error("high voltage id without read strobe");
endmodule : fcs_cycle

// ==== design/fcs_apb.sv ====
// APB slave holding the controller's own command, address, data registers.
// Assumes the sequencer reports busy, identification mode, protection, error and read data.
`timescale 1ns/1ns
module fcs_apb (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pslverr_q,
  output logic cmd_go,
  output logic [3:0] cmd_op,
  output logic [17:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] status,
  input wire logic [7:0] rdata
);
  import fcs_pkg::*;
  logic [3:0] op_q, op_d;
  logic [17:0] a_q, a_d;
  logic [7:0] w_q, w_d;
  logic [31:0] pr_d;
  logic err_d, acc;

  // Zero wait state slave: pready is a register at the top, set high once out of reset while ce is high
  always_comb begin
    acc = psel && penable;
    op_d = op_q;
    a_d = a_q;
    w_d = w_q;
    pr_d = prdata_q;
    err_d = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        REG_CMD: pr_d = {28'h000_0000, op_q};
        REG_ADDR: pr_d = {14'h0000, a_q};
        REG_WDATA: pr_d = {24'h00_0000, w_q};
        REG_STATUS: pr_d = {24'h00_0000, status};
        REG_RDATA: pr_d = {24'h00_0000, rdata};
        default: pr_d = 32'h0000_0000;
      endcase
      // Error registered in setup so it stands at the access edge with pready
      err_d = !(paddr == REG_CMD || paddr == REG_ADDR || paddr == REG_WDATA ||
        paddr == REG_STATUS || paddr == REG_RDATA);
    end
    if (acc) begin
      if (pwrite && paddr == REG_CMD) op_d = pwdata[3:0];
      if (pwrite && paddr == REG_ADDR) a_d = pwdata[17:0];
      if (pwrite && paddr == REG_WDATA) w_d = pwdata[7:0];
    end
  end

  // Register file, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_q <= 4'h0;
      a_q <= 18'h0_0000;
      w_q <= 8'h00;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      op_q <= op_d;
      a_q <= a_d;
      w_q <= w_d;
      prdata_q <= pr_d;
      pslverr_q <= err_d;
    end
  end

  // Command write starts an operation in the same access edge
  assign cmd_go = ce && psel && penable && pwrite && paddr == REG_CMD;
  assign cmd_op = pwdata[3:0];
  assign cmd_addr = a_q;
  assign cmd_wdata = w_q;
endmodule : fcs_apb

// ==== design/fcs_ctrl.sv ====
// Host controller for a byte-wide parallel flash: issues command sequences,
// identification reads, programming and end-of-write polling.
// Assumes flash pins are synchronous to clk and an APB master drives software.
`timescale 1ns/1ns
module fcs_ctrl #(
  parameter int LOCK_WAIT = fcs_pkg::LOCK_PAUSE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic id_high_voltage_line,
  output logic [17:0] flash_addr,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in
);
  import fcs_pkg::*;
  typedef enum logic [2:0] {
    FCS_S_IDLE, FCS_S_SEQ, FCS_S_WAIT, FCS_S_POLL, FCS_S_PAUSE
  } fcs_state_t;

  fcs_cyc_if cyc ();
  logic cmd_go;
  logic [3:0] cmd_op;
  logic [17:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic [7:0] status, rdata_q, rdata_d;
  fcs_state_t st_q, st_d;
  logic [3:0] op_q, op_d;
  logic [2:0] idx_q, idx_d;
  logic [31:0] cnt_q, cnt_d;
  logic [7:0] prev_q, prev_d;
  logic first_q, first_d;
  logic req_q, req_d, wr_q, wr_d, hv_q, hv_d;
  logic [17:0] ca_q, ca_d, ua_q, ua_d;
  logic [7:0] cw_q, cw_d, uw_q, uw_d;
  logic id_mode_q, id_mode_d, prot_q, prot_d, err_q, err_d;
  logic [2:0] len;

  // Number of writes in each command, including trailing byte where present
  function automatic logic [2:0] seq_len(input logic [3:0] op);
    case (fcs_op_t'(op))
      FCS_OP_PROG: seq_len = 3'd4;
      // short entry offered, the preferred form for software
      FCS_OP_ID_ENTER3, FCS_OP_ID_EXIT: seq_len = 3'd3;
      FCS_OP_LOCK_FIRST, FCS_OP_LOCK_LAST: seq_len = 3'd7;
      FCS_OP_ID_ENTER6, FCS_OP_PROT_OFF, FCS_OP_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd0;
    endcase
  endfunction : seq_len

  // Address of write number i; unlock writes 1 and 4 go to the second address
  function automatic logic [17:0] seq_addr(input logic [3:0] op, input logic [2:0] i,
      input logic [17:0] ua);
    if (i == 3'd6)
      seq_addr = (fcs_op_t'(op) == FCS_OP_LOCK_LAST) ? LOCK_LAST_ADDR : LOCK_FIRST_ADDR;
    else if (fcs_op_t'(op) == FCS_OP_PROG && i == 3'd3)
      seq_addr = ua;
    else
      seq_addr = (i == 3'd1 || i == 3'd4) ? CMD_ADDR_B : CMD_ADDR_A;
  endfunction : seq_addr

  // Data of write number i for command op
  function automatic logic [7:0] seq_data(input logic [3:0] op, input logic [2:0] i,
      input logic [7:0] uw);
    case (i)
      3'd0, 3'd3: seq_data = D_AA;
      3'd1, 3'd4: seq_data = D_55;
      default: seq_data = 8'h00;
    endcase
    if (i == 3'd2) begin
      case (fcs_op_t'(op))
        FCS_OP_ID_ENTER3: seq_data = D_ID3;
        FCS_OP_ID_EXIT: seq_data = D_EXIT;
        FCS_OP_PROG: seq_data = D_PROT_ON;
        default: seq_data = D_80;
      endcase
    end
    if (fcs_op_t'(op) == FCS_OP_PROG && i == 3'd3) seq_data = uw;
    if (i == 3'd5) begin
      case (fcs_op_t'(op))
        FCS_OP_ID_ENTER6: seq_data = D_ID6;
        FCS_OP_PROT_OFF: seq_data = D_PROT_OFF;
        FCS_OP_ERASE: seq_data = D_ERASE;
        default: seq_data = D_LOCK;
      endcase
    end
    if (i == 3'd6)
      seq_data = (fcs_op_t'(op) == FCS_OP_LOCK_LAST) ? LOCK_LAST_DATA : LOCK_FIRST_DATA;
  endfunction : seq_data

  fcs_apb u_apb (
    .clk(clk), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata), .pslverr_q(pslverr),
    .cmd_go(cmd_go), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .status(status), .rdata(rdata_q)
  );

  fcs_cycle u_cycle (
    .clk(clk), .reset_n(reset_n), .ce(ce), .cyc(cyc.eng),
    .chip_sel_n_q(chip_sel_n), .out_en_n_q(out_en_n), .wr_en_n_q(wr_en_n),
    .id_high_voltage_line_q(id_high_voltage_line), .addr_q(flash_addr),
    .dq_out_q(dq_out), .dq_oe_q(dq_oe), .dq_in(dq_in)
  );

  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.hv = hv_q;
  assign cyc.addr = ca_q;
  assign cyc.wdata = cw_q;
  assign status = {3'b000, err_q, prot_q, id_mode_q, 1'b0, st_q != FCS_S_IDLE};
  assign len = seq_len(op_q);

  // Sequencer: issue writes, then poll or pause; single reads wait for their cycle
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    prev_d = prev_q;
    first_d = first_q;
    req_d = req_q;
    wr_d = wr_q;
    hv_d = hv_q;
    ca_d = ca_q;
    cw_d = cw_q;
    ua_d = ua_q;
    uw_d = uw_q;
    rdata_d = rdata_q;
    id_mode_d = id_mode_q;
    prot_d = prot_q;
    err_d = err_q;
    case (st_q)
      FCS_S_IDLE: begin
        if (cmd_go) begin
          op_d = cmd_op;
          ua_d = cmd_addr;
          uw_d = cmd_wdata;
          idx_d = 3'd0;
          err_d = 1'b0;
          req_d = 1'b1;
          hv_d = 1'b0;
          first_d = 1'b1;
          if (fcs_op_t'(cmd_op) == FCS_OP_READ || fcs_op_t'(cmd_op) == FCS_OP_POLL ||
              fcs_op_t'(cmd_op) == FCS_OP_HW_ID) begin
            wr_d = 1'b0;
            ca_d = cmd_addr;
            hv_d = fcs_op_t'(cmd_op) == FCS_OP_HW_ID;
            st_d = (fcs_op_t'(cmd_op) == FCS_OP_POLL) ? FCS_S_POLL : FCS_S_WAIT;
          end else if (seq_len(cmd_op) != 3'd0) begin
            // low fifteen bits carry the command address
            wr_d = 1'b1;
            ca_d = seq_addr(cmd_op, 3'd0, cmd_addr);
            cw_d = seq_data(cmd_op, 3'd0, cmd_wdata);
            st_d = FCS_S_SEQ;
          end else begin
            req_d = 1'b0;
            err_d = 1'b1;
          end
        end
      end
      FCS_S_SEQ: begin
        if (cyc.done) begin
          if (idx_q + 3'd1 == len) begin
            req_d = 1'b0;
            cnt_d = 32'h0000_0000;
            if (fcs_op_t'(op_q) == FCS_OP_ID_ENTER6 || fcs_op_t'(op_q) == FCS_OP_ID_ENTER3)
              id_mode_d = 1'b1;
            if (fcs_op_t'(op_q) == FCS_OP_ID_EXIT)
              id_mode_d = 1'b0;
            if (fcs_op_t'(op_q) == FCS_OP_PROG) prot_d = 1'b1;
            if (fcs_op_t'(op_q) == FCS_OP_PROT_OFF) prot_d = 1'b0;
            // Program, erase and protection off finish by toggle polling of the device
            if (fcs_op_t'(op_q) == FCS_OP_PROG || fcs_op_t'(op_q) == FCS_OP_ERASE ||
                fcs_op_t'(op_q) == FCS_OP_PROT_OFF) begin
              ca_d = ua_q;
              wr_d = 1'b0;
              req_d = 1'b1;
              st_d = FCS_S_POLL;
            end else begin
              st_d = FCS_S_PAUSE;
            end
          end else begin
            idx_d = idx_q + 3'd1;
            ca_d = seq_addr(op_q, idx_q + 3'd1, ua_q);
            cw_d = seq_data(op_q, idx_q + 3'd1, uw_q);
          end
        end
      end
      FCS_S_WAIT: begin
        if (cyc.done) begin
          req_d = 1'b0;
          rdata_d = cyc.rdata;
          st_d = FCS_S_IDLE;
        end
      end
      FCS_S_POLL: begin
        // compare toggle bit of successive reads
        if (cyc.done) begin
          rdata_d = cyc.rdata;
          prev_d = cyc.rdata;
          first_d = 1'b0;
          // two reads with the same toggle bit mean the cycle has ended
          if (!first_q && cyc.rdata[6] == prev_q[6]) begin
            req_d = 1'b0;
            st_d = FCS_S_IDLE;
          end
        end
      end
      FCS_S_PAUSE: begin
        cnt_d = cnt_q + 32'h0000_0001;
        // long pause after lockout, short after identification commands
        if (cnt_q + 32'h0000_0001 >= ((fcs_op_t'(op_q) == FCS_OP_LOCK_FIRST ||
            fcs_op_t'(op_q) == FCS_OP_LOCK_LAST) ? 32'(LOCK_WAIT) : 32'(ID_PAUSE_CYC)))
          st_d = FCS_S_IDLE;
      end
      default: st_d = FCS_S_IDLE;
    endcase
  end

  // Sequencer registers; protection assumed on after reset as shipped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= FCS_S_IDLE;
      op_q <= 4'h0;
      idx_q <= 3'd0;
      cnt_q <= 32'h0000_0000;
      prev_q <= 8'h00;
      first_q <= 1'b1;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      hv_q <= 1'b0;
      ca_q <= 18'h0_0000;
      cw_q <= 8'h00;
      ua_q <= 18'h0_0000;
      uw_q <= 8'h00;
      rdata_q <= 8'h00;
      id_mode_q <= 1'b0;
      prot_q <= 1'b1;
      err_q <= 1'b0;
      pready <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      prev_q <= prev_d;
      first_q <= first_d;
      req_q <= req_d;
      wr_q <= wr_d;
      hv_q <= hv_d;
      ca_q <= ca_d;
      cw_q <= cw_d;
      ua_q <= ua_d;
      uw_q <= uw_d;
      rdata_q <= rdata_d;
      id_mode_q <= id_mode_d;
      prot_q <= prot_d;
      err_q <= err_d;
      pready <= 1'b1;
    end
  end

  // Short identification entry must be followed by at least 8 cycles of pause
  sequence s_id_done;
    st_q == FCS_S_SEQ && cyc.done && fcs_op_t'(op_q) == FCS_OP_ID_ENTER3 && idx_q == 3'd2;
  endsequence
  a_id_pause_len: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    s_id_done |=> st_q == FCS_S_PAUSE [*8]) else $error("identification pause too short");
  a_id_mode_set: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    s_id_done |=> id_mode_q) else $error("identification mode not recorded");
  a_first_unlock: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == FCS_S_SEQ && idx_q == 3'd0 |-> ca_q == CMD_ADDR_A && cw_q == D_AA)
    else $error("sequence does not open with unlock write");
  a_second_unlock: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == FCS_S_SEQ && idx_q == 3'd1 |-> ca_q == CMD_ADDR_B && cw_q == D_55)
    else $error("second unlock write wrong");
  a_erase_code: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == FCS_S_SEQ && idx_q == 3'd5 && fcs_op_t'(op_q) == FCS_OP_ERASE |-> cw_q == D_ERASE)
    else $error("erase code wrong");
  a_lock_tail: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == FCS_S_SEQ && idx_q == 3'd6 && fcs_op_t'(op_q) == FCS_OP_LOCK_LAST
    |-> ca_q == LOCK_LAST_ADDR && cw_q == LOCK_LAST_DATA) else $error("lockout tail wrong");
  a_exit_clear: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    st_q == FCS_S_SEQ && cyc.done && fcs_op_t'(op_q) == FCS_OP_ID_EXIT && idx_q == 3'd2
    |=> !id_mode_q) else $error("exit did not clear identification mode");
  a_poll_stop: assert property (@(posedge clk) disable iff (!reset_n || !ce)
    st_q == FCS_S_POLL && cyc.done && !first_q && cyc.rdata[6] == prev_q[6]
    |=> st_q == FCS_S_IDLE) else $error("poll did not stop on steady toggle bit");
endmodule : fcs_ctrl

// ==== bench/fcs_flash_model.sv ====
// Behavioural flash device on the far side of the host controller.
// Assumes strobes and address are synchronous to clk.
`timescale 1ns/1ns
module fcs_flash_model #(
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary code
  parameter logic [7:0] DEV = 8'hC3, // Arbitrary code
  parameter int BUSY = 200
) (
  input wire logic clk,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv,
  input wire logic [17:0] a,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] mem [logic [17:0]];
  logic [17:0] ha [0:6];
  logic [7:0] hd [0:6];
  logic [17:0] la;
  // Device powers up in normal read mode
  logic idm = 0, lk0 = 0, lk1 = 0, tog = 0, pw = 1, po = 1, p3, p6, arm = 0;
  logic [7:0] v;
  int busy = 0;
  function automatic logic m(int i, logic [14:0] x, logic [7:0] y);
    return ha[i][14:0] == x && hd[i] == y;
  endfunction : m
  // Released data bus shows a changing pattern, not the last byte
  always @(posedge clk) begin
    if (busy > 0) busy--;
    if (!po && oe_n && busy > 0) tog = ~tog;
    if (!pw && we_n) begin
      for (int i = 6; i > 0; i--) begin
        ha[i] = ha[i-1];
        hd[i] = hd[i-1];
      end
      ha[0] = a;
      hd[0] = d;
      p3 = m(2, 15'h5555, 8'hAA) && m(1, 15'h2AAA, 8'h55);
      p6 = m(5, 15'h5555, 8'hAA) && m(4, 15'h2AAA, 8'h55) && m(3, 15'h5555, 8'h80) && p3;
      if ((p3 && m(0, 15'h5555, 8'h90)) || (p6 && m(0, 15'h5555, 8'h60))) idm = 1;
      if (p3 && m(0, 15'h5555, 8'hF0)) idm = 0;
      if (p6 && m(0, 15'h5555, 8'h10) && !lk0 && !lk1) begin
        mem.delete();
        busy = BUSY;
      end
      if (arm && a == 18'h0_0000 && d == 8'h00) lk0 = 1;
      if (arm && a == 18'h3_FFFF && d == 8'hFF) lk1 = 1;
      arm = p6 && m(0, 15'h5555, 8'h40);
      if (m(3, 15'h5555, 8'hAA) && m(2, 15'h2AAA, 8'h55) && m(1, 15'h5555, 8'hA0)
          && !(lk0 && a < 18'h0_2000) && !(lk1 && a >= 18'h3_E000)) begin
        mem[a] = d;
        la = a;
        busy = BUSY;
      end
    end
    v = mem.exists(a) ? mem[a] : 8'hFF;
    if (hv) v = a[0] ? DEV : MAKER;
    else if (idm && a < 18'h0_0003) v = (a == 0) ? MAKER : (a == 1) ? DEV : {7'h7F, lk0};
    else if (idm && a == 18'h3_FFF2) v = {7'h7F, lk1};
    else if (busy > 0 && a == la) v = {~v[7], tog, v[5:0]};
    q <= (!cs_n && !oe_n) ? v : ~q;
    pw = we_n;
    po = oe_n;
  end
endmodule : fcs_flash_model

// ==== bench/tb.sv ====
// Self-checking bench for the flash host controller over APB.
// Assumes the behavioural flash model answers on the flash pins.
`timescale 1ns/1ns
module tb;
  import fcs_pkg::*;
  logic clk, reset_n, ce, se, psel, penable, pwrite, pready, pslverr, cs_n, oe_n, we_n, hv, oe;
  logic [7:0] paddr, dq_out, dq_in, pd;
  logic [31:0] pwdata, prdata, r, seed;
  logic [17:0] fa, pa;
  logic [17:0] ia [$] = '{18'h0_0000, 18'h0_0001, 18'h0_0002, 18'h3_FFF2};
  logic [7:0] ie [$] = '{8'h5A, 8'hC3, 8'hFF, 8'hFE};
  int n_mismatch = 0, cmp_count = 0;
  fcs_ctrl #(.LOCK_WAIT(50)) i_fcs_ctrl (.clk(clk), .reset_n(reset_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_sel_n(cs_n),
    .out_en_n(oe_n), .wr_en_n(we_n), .id_high_voltage_line(hv), .flash_addr(fa),
    .dq_out(dq_out), .dq_oe(oe), .dq_in(dq_in));
  // Write data reaches the model only while the controller enables its drivers
  fcs_flash_model i_fcs_flash_model (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .hv(hv), .a(fa), .d(oe ? dq_out : ~dq_out), .q(dq_in));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Xorshift step for random stimulus
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] wd);
    int n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    r = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  // Issue one operation, poll busy, fetch read data
  task automatic op(logic [3:0] c, logic [17:0] a, logic [7:0] d);
    int n = 0;
    apb(1, REG_ADDR, {14'h0, a});
    apb(1, REG_WDATA, {24'h0, d});
    apb(1, REG_CMD, {28'h0, c});
    do begin
      apb(0, REG_STATUS, 0);
      n++;
    end while (r[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
    apb(0, REG_RDATA, 0);
  endtask : op
  initial begin
    {psel, penable, pwrite, reset_n} = 0;
    ce = 1;
    paddr = 0;
    pwdata = 0;
    seed = 32'h0000_ae85;
    repeat (3) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    apb(0, 8'h20, 32'h1234_5678);
    chk("unmapped", 0, r);
    chk("pslverr", 1, se);
    seed = xs(seed);
    pa = {2'b01, seed[15:0]};
    pd = seed[23:16];
    op(FCS_OP_PROG, pa, pd);
    op(FCS_OP_READ, pa, 0);
    chk("prog", pd, r[7:0]);
    op(FCS_OP_POLL, pa, 0);
    chk("poll", pd, r[7:0]);
    op(FCS_OP_LOCK_FIRST, 0, 0);
    op(FCS_OP_ID_ENTER3, 0, 0);
    apb(0, REG_STATUS, 0);
    chk("prot id bits", 2'b11, r[3:2]);
    chk("pslverr mapped", 0, se);
    foreach (ia[i]) begin
      op(FCS_OP_READ, ia[i], 0);
      chk("id read", ie[i], r[7:0]);
    end
    op(FCS_OP_ID_EXIT, 0, 0);
    op(FCS_OP_ERASE, 0, 0);
    op(FCS_OP_READ, pa, 0);
    chk("erase refused", pd, r[7:0]);
    op(FCS_OP_PROG, 18'h0_0100, pd);
    op(FCS_OP_READ, 18'h0_0100, 0);
    chk("locked write", 8'hFF, r[7:0]);
    op(FCS_OP_ID_ENTER6, 0, 0);
    op(FCS_OP_READ, 1, 0);
    chk("id6 device", ie[1], r[7:0]);
    op(FCS_OP_LOCK_LAST, 0, 0);
    op(FCS_OP_READ, ia[3], 0);
    chk("lock last", 8'hFF, r[7:0]);
    op(FCS_OP_ID_EXIT, 0, 0);
    for (int i = 0; i < 2; i++) begin
      op(FCS_OP_HW_ID, i, 0);
      chk("hw id", ie[i], r[7:0]);
    end
    op(FCS_OP_PROT_OFF, 0, 0);
    apb(0, REG_STATUS, 0);
    chk("prot off", 0, r[3]);
    op(4'hF, 0, 0);
    apb(0, REG_STATUS, 0);
    chk("bad op", 1, r[4]);
    // Registers must hold while the clock enable is low
    ce <= 0;
    apb(1, REG_ADDR, 32'h0000_1234);
    ce <= 1;
    apb(0, REG_ADDR, 0);
    chk("ce freeze", 0, r);
    tally_and_finish();
  end
endmodule : tb
